// *** hw/sfid_regs.svh ***
// opcode, count and timing constants of the identification/power/suspend command block
`ifndef SFID_REGS_SVH
`define SFID_REGS_SVH

// ----------------------------------------------------------------------------
// opcodes handled or screened by the block
// ----------------------------------------------------------------------------
`define SFID_OP_RELEASE   8'hAB
`define SFID_OP_MDID_1    8'h90
`define SFID_OP_MDID_2    8'h92
`define SFID_OP_MDID_4    8'h94
`define SFID_OP_JEDEC     8'h9F
`define SFID_OP_HPM       8'hA3
`define SFID_OP_DPD       8'hB9
`define SFID_OP_SUSPEND   8'h75
`define SFID_OP_RST_EN    8'h66
`define SFID_OP_RST       8'h99
`define SFID_OP_WRSR_1    8'h01
`define SFID_OP_WRSR_2    8'h31
`define SFID_OP_WRSR_3    8'h11
`define SFID_OP_SEC_ERASE 8'h44
`define SFID_OP_SEC_PROG  8'h42
`define SFID_OP_ERASE_4K  8'h20
`define SFID_OP_ERASE_32K 8'h52
`define SFID_OP_ERASE_64K 8'hD8
`define SFID_OP_ERASE_C1  8'hC7
`define SFID_OP_ERASE_C2  8'h60
`define SFID_OP_PROG_1    8'h02
`define SFID_OP_PROG_4    8'h32

// ----------------------------------------------------------------------------
// serial clock counts, counted in rising edges of the serial clock
// ----------------------------------------------------------------------------
`define SFID_OPC_CLK      6'd8
`define SFID_CLK_SAT      6'd63
`define SFID_REL_IN_CLK   6'd24
`define SFID_HPM_IN_CLK   6'd24
`define SFID_MD1_ADR_CLK  6'd24
`define SFID_MD2_ADR_CLK  6'd12
`define SFID_MD4_ADR_CLK  6'd6
`define SFID_MD4_DMY_CLK  6'd4
`define SFID_JEDEC_IN_CLK 6'd0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SFID_CLK_MHZ      200
`define SFID_REL_NS       3000
`define SFID_REL_ID_NS    3000

`endif

// *** hw/sfid_pkg.sv ***
// types shared by the identification/power/suspend command block
package sfid_pkg;

    // ------------------------------------------------------------------------
    // frame sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SFID_ST_IDLE, // deselected
        SFID_ST_CMD,  // shifting opcode
        SFID_ST_IN,   // address and dummy clocks
        SFID_ST_OUT,  // driving identification data
        SFID_ST_SKIP  // frame ignored until deselect
    } sfid_state_e;

    // data lanes used by a read
    typedef enum logic [1:0] {
        SFID_LANE_1,
        SFID_LANE_2,
        SFID_LANE_4
    } sfid_lane_e;

    // status coming from the program/erase engine
    typedef struct packed {
        logic busy;       // self-timed cycle running
        logic is_program; // running cycle is a page program
        logic is_erase;   // running cycle is a sector/block erase
        logic resume;     // pulse: engine resumed, suspend ends
    } sfid_core_s;

    // status presented to the rest of the device
    typedef struct packed {
        logic write_in_progress_flag;
        logic [1:0] suspend_flags; // [1] program, [0] erase
        logic high_perf_mode;
        logic deep_power_down;
        logic cmd_ready;
    } sfid_stat_s;

    // opcode hand-off to the rest of the command decoder
    typedef struct packed {
        logic valid;       // pulse: opcode passed on
        logic blocked;     // pulse: opcode refused while suspended
        logic [7:0] opcode;
    } sfid_fwd_s;

    // request to the program/erase engine
    typedef struct packed {
        logic suspend_req; // pulse: accepted suspend
        logic dpd_enter;   // pulse: enter deep power-down
    } sfid_req_s;

endpackage : sfid_pkg

// *** hw/sfid_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sfid_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q; // first stage, read only by the second

    // two flops in series
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '1;
            q <= '1;
        end else if (clk_en) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sfid_sync

// *** hw/sfid_shift.sv ***
// identification data shifter driving the io pins
`timescale 1ns/1ps
module sfid_shift
    import sfid_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [23:0] pattern,
    input wire logic len16,
    input wire sfid_pkg::sfid_lane_e lanes,
    input wire logic shift,
    input wire logic stop,
    output logic [3:0] io_out_q,
    output logic [3:0] io_oe_q
);
    logic [23:0] data_q; // pattern being sent
    logic started_q; // first falling edge seen
    logic [23:0] data_d;

    // rotate within 16 or 24 bits by the lane width
    function automatic logic [23:0] rot(input logic [23:0] r, input logic l16, input sfid_lane_e w);
        logic [23:0] o;
        o = r;
        case (w)
            SFID_LANE_1: o = l16 ? {r[22:8], r[23], r[7:0]} : {r[22:0], r[23]};
            SFID_LANE_2: o = l16 ? {r[21:8], r[23:22], r[7:0]} : {r[21:0], r[23:22]};
            SFID_LANE_4: o = l16 ? {r[19:8], r[23:20], r[7:0]} : {r[19:0], r[23:20]};
            default: o = r;
        endcase
        return o;
    endfunction : rot

    // next word: first fall shows the msb, later falls advance
    always_comb begin
        data_d = started_q ? rot(data_q, len16, lanes) : data_q;
    end

    // data and pin drive, updated on falling serial clock
    always_ff @(posedge clk) begin
        if (srst) begin
            data_q <= 24'h00_0000;
            started_q <= 1'b0;
            io_out_q <= 4'h0;
            io_oe_q <= 4'h0;
        end else if (clk_en) begin
            if (stop) begin
                started_q <= 1'b0;
                io_oe_q <= 4'h0;
            end else if (load) begin
                data_q <= pattern;
                started_q <= 1'b0;
            end else if (shift) begin
                data_q <= data_d;
                started_q <= 1'b1;
                case (lanes)
                    SFID_LANE_2: begin
                        io_out_q <= {2'b00, data_d[23:22]};
                        io_oe_q <= 4'b0011;
                    end
                    SFID_LANE_4: begin
                        io_out_q <= data_d[23:20];
                        io_oe_q <= 4'b1111;
                    end
                    default: begin
                        io_out_q <= {2'b00, data_d[23], 1'b0};
                        io_oe_q <= 4'b0010;
                    end
                endcase
            end
        end
    end
endmodule : sfid_shift

// *** hw/sfid_top.sv ***
// serial flash identification, power-mode and suspend command interpreter
`timescale 1ns/1ps
`include "sfid_regs.svh"
module sfid_top
    import sfid_pkg::*;
#(
    parameter int REL_NS = `SFID_REL_NS,
    parameter int REL_ID_NS = `SFID_REL_ID_NS,
    parameter logic [7:0] MAKER_ID = 8'h5A,  // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h3C, // arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h41,  // arbitrary value
    parameter logic [7:0] CAPACITY = 8'h17   // arbitrary value
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic [3:0] spi_io_in,
    output logic [3:0] spi_io_out,
    output logic [3:0] spi_io_oe,
    input wire sfid_pkg::sfid_core_s core,
    output sfid_pkg::sfid_stat_s stat_q,
    output sfid_pkg::sfid_fwd_s fwd_q,
    output sfid_pkg::sfid_req_s req_q
);
    import sfid_pkg::*;

    // ------------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------------
    localparam int REL_CYC_I = (REL_NS * `SFID_CLK_MHZ + 999) / 1000;
    localparam int REL_ID_CYC_I = (REL_ID_NS * `SFID_CLK_MHZ + 999) / 1000;
    localparam logic [15:0] REL_CYC = 16'(REL_CYC_I < 1 ? 1 : REL_CYC_I);
    localparam logic [15:0] REL_ID_CYC = 16'(REL_ID_CYC_I < 1 ? 1 : REL_ID_CYC_I);

    // ------------------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------------------
    // clocks between opcode and data
    function automatic logic [5:0] in_clocks(input logic [7:0] op);
        case (op)
            `SFID_OP_RELEASE: in_clocks = `SFID_REL_IN_CLK;
            `SFID_OP_HPM: in_clocks = `SFID_HPM_IN_CLK;
            `SFID_OP_MDID_1: in_clocks = `SFID_MD1_ADR_CLK;
            `SFID_OP_MDID_2: in_clocks = `SFID_MD2_ADR_CLK;
            `SFID_OP_MDID_4: in_clocks = `SFID_MD4_ADR_CLK + `SFID_MD4_DMY_CLK;
            default: in_clocks = `SFID_JEDEC_IN_CLK;
        endcase
    endfunction : in_clocks

    // address clocks of the maker/device reads
    function automatic logic [5:0] adr_clocks(input logic [7:0] op);
        case (op)
            `SFID_OP_MDID_1: adr_clocks = `SFID_MD1_ADR_CLK;
            `SFID_OP_MDID_2: adr_clocks = `SFID_MD2_ADR_CLK;
            `SFID_OP_MDID_4: adr_clocks = `SFID_MD4_ADR_CLK;
            default: adr_clocks = 6'd0;
        endcase
    endfunction : adr_clocks

    // lane width of address and data
    function automatic sfid_lane_e lane_of(input logic [7:0] op);
        case (op)
            `SFID_OP_MDID_2: lane_of = SFID_LANE_2;
            `SFID_OP_MDID_4: lane_of = SFID_LANE_4;
            default: lane_of = SFID_LANE_1;
        endcase
    endfunction : lane_of

    // commands handled in this block
    function automatic logic is_local(input logic [7:0] op);
        is_local = (op == `SFID_OP_RELEASE) || (op == `SFID_OP_MDID_1) || (op == `SFID_OP_MDID_2)
            || (op == `SFID_OP_MDID_4) || (op == `SFID_OP_JEDEC) || (op == `SFID_OP_HPM)
            || (op == `SFID_OP_DPD) || (op == `SFID_OP_SUSPEND);
    endfunction : is_local

    // commands refused during suspend
    function automatic logic refused(input logic [7:0] op, input logic [1:0] sus);
        logic wr_sr;
        logic erase;
        wr_sr = (op == `SFID_OP_WRSR_1) || (op == `SFID_OP_WRSR_2) || (op == `SFID_OP_WRSR_3);
        erase = (op == `SFID_OP_ERASE_4K) || (op == `SFID_OP_ERASE_32K) || (op == `SFID_OP_ERASE_64K)
            || (op == `SFID_OP_ERASE_C1) || (op == `SFID_OP_ERASE_C2) || (op == `SFID_OP_SEC_ERASE);
        refused = (sus[1] && (wr_sr || erase || (op == `SFID_OP_SEC_PROG)
                || (op == `SFID_OP_PROG_1) || (op == `SFID_OP_PROG_4)))
            || (sus[0] && (wr_sr || erase));
    endfunction : refused

    // ------------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------------
    logic [5:0] pin_s; // synchronised cs_n, sclk, io
    logic cs_s;
    logic sclk_s;
    logic [3:0] io_s;
    logic sclk_d_q; // previous serial clock level
    logic cs_d_q; // previous select level
    logic rise;
    logic fall;
    logic cs_up;

    sfid_sync #(.W(6)) u_sync (
        .clk(clk),
        .srst(srst),
        .clk_en(clk_en),
        .d({spi_cs_n, spi_sclk, spi_io_in}),
        .q(pin_s)
    );

    assign cs_s = pin_s[5];
    assign sclk_s = pin_s[4];
    assign io_s = pin_s[3:0];
    assign rise = sclk_s && !sclk_d_q && !cs_s;
    assign fall = !sclk_s && sclk_d_q && !cs_s;
    assign cs_up = cs_s && !cs_d_q;

    // edge detection history
    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end else if (clk_en) begin
            sclk_d_q <= sclk_s;
            cs_d_q <= cs_s;
        end
    end

    // ------------------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------------------
    sfid_state_e st_q; // frame state
    logic [7:0] op_q; // opcode shift register
    logic [5:0] clk_cnt_q; // rising edges in this frame
    logic adr0_q; // address bit 0 of maker/device reads
    logic [7:0] op_d;
    logic [5:0] post_cnt; // rising edges after the opcode
    logic opc_done; // this edge completes the opcode
    logic accept; // completed opcode taken by this block
    logic in_done; // this edge completes address/dummies
    logic is_id;
    logic load;
    logic [23:0] pattern;

    assign op_d = {op_q[6:0], io_s[0]};
    assign post_cnt = clk_cnt_q - `SFID_OPC_CLK;
    assign opc_done = rise && (st_q == SFID_ST_CMD) && (clk_cnt_q == `SFID_OPC_CLK - 6'd1);
    assign is_id = (op_q == `SFID_OP_RELEASE) || (op_q == `SFID_OP_MDID_1) || (op_q == `SFID_OP_MDID_2)
        || (op_q == `SFID_OP_MDID_4);
    assign in_done = rise && (st_q == SFID_ST_IN) && is_id && (post_cnt == in_clocks(op_q) - 6'd1);

    // acceptance of the completed opcode
    always_comb begin
        accept = stat_q.cmd_ready && is_local(op_d);
        if (stat_q.deep_power_down && (op_d != `SFID_OP_RELEASE)) begin
            accept = 1'b0;
        end
        if (stat_q.write_in_progress_flag && (op_d == `SFID_OP_RELEASE)) begin
            accept = 1'b0;
        end
        if (stat_q.write_in_progress_flag && (op_d == `SFID_OP_JEDEC)) begin
            accept = 1'b0;
        end
    end

    // state, opcode and clock count; deselect drops any partial frame
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= SFID_ST_IDLE;
            op_q <= 8'h00;
            clk_cnt_q <= 6'd0;
        end else if (clk_en) begin
            if (cs_s) begin
                st_q <= SFID_ST_IDLE;
                clk_cnt_q <= 6'd0;
            end else begin
                if (rise && (clk_cnt_q != `SFID_CLK_SAT)) begin
                    clk_cnt_q <= clk_cnt_q + 6'd1;
                end
                case (st_q)
                    SFID_ST_IDLE: st_q <= SFID_ST_CMD;
                    SFID_ST_CMD: begin
                        if (rise) begin
                            op_q <= op_d;
                        end
                        if (opc_done) begin
                            if (!accept) begin
                                st_q <= SFID_ST_SKIP;
                            end else if (op_d == `SFID_OP_JEDEC) begin
                                st_q <= SFID_ST_OUT;
                            end else if ((op_d == `SFID_OP_DPD) || (op_d == `SFID_OP_SUSPEND)) begin
                                st_q <= SFID_ST_CMD;
                            end else begin
                                st_q <= SFID_ST_IN;
                            end
                        end
                    end
                    SFID_ST_IN: begin
                        if (in_done) begin
                            st_q <= SFID_ST_OUT;
                        end
                    end
                    SFID_ST_OUT: st_q <= SFID_ST_OUT;
                    SFID_ST_SKIP: st_q <= SFID_ST_SKIP;
                    default: st_q <= SFID_ST_IDLE;
                endcase
            end
        end
    end

    // address bit 0 of the maker/device reads, on io0 of the last address clock
    always_ff @(posedge clk) begin
        if (srst) begin
            adr0_q <= 1'b0;
        end else if (clk_en) begin
            if (rise && (st_q == SFID_ST_IN) && (post_cnt < adr_clocks(op_q))) begin
                adr0_q <= io_s[0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // identification output
    // ------------------------------------------------------------------------
    // pattern per command; maker/device pair rotates in 16 bits
    always_comb begin
        load = in_done || (opc_done && accept && (op_d == `SFID_OP_JEDEC));
        if (opc_done) begin
            pattern = {MAKER_ID, MEM_TYPE, CAPACITY};
        end else if (op_q == `SFID_OP_RELEASE) begin
            pattern = {DEVICE_ID, DEVICE_ID, DEVICE_ID};
        end else if ((in_done && (post_cnt < adr_clocks(op_q))) ? io_s[0] : adr0_q) begin
            pattern = {DEVICE_ID, MAKER_ID, 8'h00};
        end else begin
            pattern = {MAKER_ID, DEVICE_ID, 8'h00};
        end
    end

    sfid_shift u_shift (
        .clk(clk),
        .srst(srst),
        .clk_en(clk_en),
        .load(load),
        .pattern(pattern),
        .len16(op_q != `SFID_OP_RELEASE && op_q != `SFID_OP_JEDEC && !opc_done),
        .lanes(opc_done ? SFID_LANE_1 : lane_of(op_q)),
        .shift(fall && (st_q == SFID_ST_OUT)),
        .stop(cs_s),
        .io_out_q(spi_io_out),
        .io_oe_q(spi_io_oe)
    );

    // ------------------------------------------------------------------------
    // end-of-frame actions
    // ------------------------------------------------------------------------
    logic bare; // frame held exactly the opcode
    logic rel_bare;
    logic rel_id;
    logic hpm_go;
    logic dpd_go;
    logic sus_go;

    assign bare = cs_up && (st_q == SFID_ST_CMD || st_q == SFID_ST_IN) && (clk_cnt_q == `SFID_OPC_CLK);
    assign rel_bare = bare && (op_q == `SFID_OP_RELEASE);
    assign rel_id = cs_up && (st_q == SFID_ST_OUT) && (op_q == `SFID_OP_RELEASE);
    assign hpm_go = cs_up && (st_q == SFID_ST_IN) && (op_q == `SFID_OP_HPM)
        && (clk_cnt_q == `SFID_OPC_CLK + `SFID_HPM_IN_CLK);
    assign dpd_go = bare && (op_q == `SFID_OP_DPD) && !stat_q.write_in_progress_flag;
    assign sus_go = bare && (op_q == `SFID_OP_SUSPEND) && stat_q.write_in_progress_flag
        && (stat_q.suspend_flags == 2'b00) && (core.is_program || core.is_erase);

    // power modes
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q.high_perf_mode <= 1'b0;
            stat_q.deep_power_down <= 1'b0;
        end else if (clk_en) begin
            if (rel_bare || rel_id || dpd_go) begin
                stat_q.high_perf_mode <= 1'b0;
            end else if (hpm_go) begin
                stat_q.high_perf_mode <= 1'b1;
            end
            if (rel_bare || rel_id) begin
                stat_q.deep_power_down <= 1'b0;
            end else if (dpd_go) begin
                stat_q.deep_power_down <= 1'b1;
            end
        end
    end

    // release recovery; commands are refused until it ends
    logic [15:0] rec_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            rec_q <= 16'h0000;
            stat_q.cmd_ready <= 1'b1;
        end else if (clk_en) begin
            if (rel_bare || (rel_id && stat_q.deep_power_down)) begin
                rec_q <= rel_bare ? REL_CYC : REL_ID_CYC;
                stat_q.cmd_ready <= 1'b0;
            end else if (rec_q > 16'h0001) begin
                rec_q <= rec_q - 16'h0001;
            end else begin
                rec_q <= 16'h0000;
                stat_q.cmd_ready <= 1'b1;
            end
        end
    end

    // write-in-progress and suspend flags; a set beats a resume
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q.write_in_progress_flag <= 1'b0;
            stat_q.suspend_flags <= 2'b00;
        end else if (clk_en) begin
            stat_q.write_in_progress_flag <= core.busy;
            if (sus_go) begin
                stat_q.suspend_flags <= {core.is_program, core.is_erase && !core.is_program};
            end else if (core.resume) begin
                stat_q.suspend_flags <= 2'b00;
            end
        end
    end

    // requests and opcode hand-off pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            req_q <= '0;
            fwd_q <= '0;
        end else if (clk_en) begin
            req_q.suspend_req <= sus_go;
            req_q.dpd_enter <= dpd_go;
            fwd_q.valid <= 1'b0;
            fwd_q.blocked <= 1'b0;
            if (opc_done && !is_local(op_d) && stat_q.cmd_ready) begin
                fwd_q.opcode <= op_d;
                if (stat_q.deep_power_down) begin
                    fwd_q.valid <= (op_d == `SFID_OP_RST_EN) || (op_d == `SFID_OP_RST);
                end else if (refused(op_d, stat_q.suspend_flags)) begin
                    fwd_q.blocked <= 1'b1;
                end else begin
                    fwd_q.valid <= 1'b1;
                end
            end
        end
    end

endmodule : sfid_top

// *** verification/sfid_checker.sv ***
// concurrent checks on the ports of the identification/power/suspend block
`timescale 1ns/1ps
module sfid_checker
    import sfid_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic spi_cs_n,
    input wire logic [3:0] spi_io_oe,
    input wire sfid_pkg::sfid_core_s core,
    input wire sfid_pkg::sfid_stat_s stat_q,
    input wire sfid_pkg::sfid_fwd_s fwd_q,
    input wire sfid_pkg::sfid_req_s req_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // recovery: ready stays low a few cycles, then comes back
    sequence s_recover; !stat_q.cmd_ready [*3] ##[1:4] stat_q.cmd_ready; endsequence
    property p_wip; stat_q.write_in_progress_flag == $past(core.busy); endproperty
    a_wip: assert property (p_wip) else $error("wip does not follow busy");
    property p_sus_ok; req_q.suspend_req |-> $past(stat_q.write_in_progress_flag) && $past(stat_q.suspend_flags) == 2'h0; endproperty
    a_sus_ok: assert property (p_sus_ok) else $error("suspend taken when not allowed");
    property p_sus_set; $rose(|stat_q.suspend_flags) |-> req_q.suspend_req; endproperty
    a_sus_set: assert property (p_sus_set) else $error("suspend flag without request");
    property p_oe_code; spi_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
    a_oe_code: assert property (p_oe_code) else $error("bad lane enable");
    property p_oe_end; $rose(spi_cs_n) |-> ##[1:6] spi_io_oe == 4'h0; endproperty
    a_oe_end: assert property (p_oe_end) else $error("pins driven after deselect");
    property p_rec; $fell(stat_q.cmd_ready) |-> s_recover; endproperty
    a_rec: assert property (p_rec) else $error("recovery length wrong");
    property p_dpd; req_q.dpd_enter |-> ##[0:1] (stat_q.deep_power_down && !stat_q.high_perf_mode); endproperty
    a_dpd: assert property (p_dpd) else $error("power-down did not leave hpm");
    property p_blk; fwd_q.blocked |-> stat_q.suspend_flags != 2'h0; endproperty
    a_blk: assert property (p_blk) else $error("opcode blocked while not suspended");
    property p_fwd_dpd; fwd_q.valid && stat_q.deep_power_down |-> fwd_q.opcode inside {8'h66, 8'h99}; endproperty
    a_fwd_dpd: assert property (p_fwd_dpd) else $error("opcode passed in power-down");
endmodule : sfid_checker
bind sfid_top sfid_checker u_chk (.clk(clk), .srst(srst), .spi_cs_n(spi_cs_n), .spi_io_oe(spi_io_oe),
    .core(core), .stat_q(stat_q), .fwd_q(fwd_q), .req_q(req_q));

// *** verification/sfid_host.sv ***
// spi host model: frames of opcode, address/dummy clocks and read clocks
`timescale 1ns/1ps
module sfid_host (
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic [31:0] got; // data captured in the read clocks
    logic [3:0] b;
    event done;
    initial {cs_n, sclk, io} = 6'h20;
    // w lanes: ac address clocks, dc dummy clocks, oc read clocks; sclk idles low
    task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int w, ac, dc, oc);
        got = '0;
        cs_n = 0;
        for (int i = 0; i < 8 + ac + dc + oc; i++) begin
            if (i < 8) io = {3'h0, op[7 - i]}; // opcode msb first on io0
            else if (i < 8 + ac) io = 4'(ad[23:20] >> (4 - w)); // address msb first
            else io = ~io; // released lines toggle
            if (i >= 8 && i < 8 + ac) ad = ad << w;
            #24 sclk = 1;
            b = io_out & io_oe;
            if (i >= 8 + ac + dc) got = (got << w) | 32'((w == 1) ? {3'h0, b[1]} : b);
            #24 sclk = 0;
        end
        #24 cs_n = 1;
        io = ~io;
        -> done;
        #200; // deselected through recovery
    endtask : frame
endmodule : sfid_host

// *** verification/sfid_top_tb.sv ***
// self-checking bench of the identification/power/suspend block
`timescale 1ns/1ps
module sfid_top_tb;
    import sfid_pkg::*;
    localparam logic [7:0] MK = 8'h5A, DV = 8'h3C, MT = 8'h41, CP = 8'h17; // arbitrary id values
    logic clk = 0, srst = 1, cs_n, sclk;
    logic [3:0] hio, io_out, io_oe;
    sfid_core_s core = '0;
    sfid_stat_s stat;
    sfid_fwd_s fwd;
    logic [1:0] fwd_seen = 0; // last hand-off kind: valid, blocked
    logic [31:0] lfsr = 32'h1afa_3bde;
    logic [31:0] expq [$];
    int err_total = 0, samples_checked = 0;
    wire [3:0] sio = (io_out & io_oe) | (hio & ~io_oe); // resolved io wires
    always #2.5 clk = ~clk;
    sfid_host u_host (.cs_n(cs_n), .sclk(sclk), .io(hio), .io_out(io_out), .io_oe(io_oe));
    sfid_top #(.REL_NS(20), .REL_ID_NS(20), .MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP)) dut (
        .clk(clk), .srst(srst), .clk_en(1'b1), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_io_in(sio),
        .spi_io_out(io_out), .spi_io_oe(io_oe), .core(core), .stat_q(stat), .fwd_q(fwd), .req_q());
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // note the expected read data, then run the frame
    task automatic rd(input logic [7:0] op, input logic [31:0] ad, input int w, ac, dc, oc, input logic [31:0] e);
        expq.push_back(e);
        u_host.frame(op, ad, w, ac, dc, oc);
    endtask : rd
    always @(u_host.done) chk("read", u_host.got, expq.pop_front());
    always @(posedge clk) if (fwd.valid || fwd.blocked) fwd_seen <= {fwd.valid, fwd.blocked};
    task automatic setcore(input logic [3:0] v);
        @(negedge clk) core = v;
    endtask : setcore
    initial begin
        repeat (20) @(negedge clk);
        srst = 0;
        repeat (5) @(negedge clk);
        rd(8'h9F, 0, 1, 0, 0, 24, {MK, MT, CP});
        rd(8'hAB, rnd(), 1, 24, 0, 16, {DV, DV});
        for (int k = 0; k < 6; k++)  // one, two, four lanes; address zero then one
            rd(8'h90 + 8'(k / 2 * 2), 32'(k % 2), 1 << k / 2, 24 >> k / 2, (k / 2 == 2) ? 4 : 0, 16 >> k / 2,
               (k % 2) ? {DV, MK} : {MK, DV});
        rd(8'hA3, rnd(), 1, 24, 0, 0, 0);
        chk("hpm", stat.high_perf_mode, 1);
        rd(8'hAB, 0, 1, 0, 0, 0, 0);
        chk("hpm", stat.high_perf_mode, 0);
        rd(8'hA3, rnd(), 1, 24, 0, 0, 0);
        rd(8'hB9, 0, 1, 0, 0, 0, 0);
        chk("dpd", {stat.deep_power_down, stat.high_perf_mode}, 2);
        rd(8'h90, 0, 1, 24, 0, 16, 0);
        rd(8'h66, 0, 1, 0, 0, 0, 0);
        chk("fwd", {fwd_seen, fwd.opcode}, {2'b10, 8'h66});
        rd(8'hAB, rnd(), 1, 24, 0, 0, 0);
        chk("dpd", stat.deep_power_down, 0);
        setcore(4'hC);
        rd(8'h9F, 0, 1, 0, 0, 24, 0);
        rd(8'hAB, rnd(), 1, 24, 0, 8, 0);
        rd(8'h75, 0, 1, 0, 0, 0, 0);
        chk("sus", stat.suspend_flags, 2);
        setcore(4'h0);
        rd(8'h02, 0, 1, 24, 0, 0, 0);
        chk("fwd", {fwd_seen, fwd.opcode}, {2'b01, 8'h02});
        rd(8'h03, 0, 1, 24, 0, 0, 0);
        chk("fwd", {fwd_seen, fwd.opcode}, {2'b10, 8'h03});
        rd(8'h9F, 0, 1, 0, 0, 24, {MK, MT, CP});
        rd(8'h75, 0, 1, 0, 0, 0, 0);
        chk("sus", stat.suspend_flags, 2);
        setcore(4'h1);
        setcore(4'h0);
        rd(8'h75, 0, 1, 0, 0, 0, 0);
        chk("sus", stat.suspend_flags, 0);
        setcore(4'hA);
        rd(8'h75, 0, 1, 0, 0, 0, 0);
        chk("sus", stat.suspend_flags, 1);
        setcore(4'h0);
        rd(8'h20, 0, 1, 24, 0, 0, 0);
        chk("fwd", {fwd_seen, fwd.opcode}, {2'b01, 8'h20});
        @(negedge clk) srst = 1;
        repeat (3) @(negedge clk);
        srst = 0;
        chk("sus", stat.suspend_flags, 0);
        repeat (5) @(negedge clk);
        finish_test();
    end
    initial begin
        #300us;
        err_total++;
        finish_test();
    end
endmodule : sfid_top_tb
